// ===== src/dfg_map.svh
`ifndef DFG_MAP_SVH
`define DFG_MAP_SVH

// Register offsets
`define DFG_HIGH_THRESHOLD_ADDR 8'h38
`define DFG_HIGH_BACKOFF_ADDR 8'h39
`define DFG_LOW_THRESHOLD_ADDR 8'h3A
`define DFG_LOW_BACKOFF_ADDR 8'h3B
`define DFG_DETECTOR_CONFIG_ADDR 8'h3C
`define DFG_FUNCTION_CHOICE_ADDR 8'h3D
`define DFG_LOGIC_INPUT_CONFIG_ADDR 8'h3E

// Field positions
`define DFG_BACKOFF_MSB 4
`define DFG_DET_GF_MSB 4
`define DFG_DET_GF_LSB 2
`define DFG_DET_KIND_MSB 1
`define DFG_SEL_MSB 1
`define DFG_FLIP_BIT 6
`define DFG_EDGE_BIT 5
`define DFG_STRETCH_MSB 4
`define DFG_STRETCH_LSB 3
`define DFG_GPI_GF_MSB 2

// Reset values
`define DFG_RESET_BYTE 8'h00

// Function choice codes
`define DFG_SEL_DET_FAULT 2'h0
`define DFG_SEL_GPI_FAULT 2'h1
`define DFG_SEL_GPI_FAULT_DET_WARN 2'h2

// Fault kind codes
`define DFG_KIND_HIGH 2'h0
`define DFG_KIND_BOTH 2'h1
`define DFG_KIND_LOW 2'h2
`define DFG_KIND_OFF 2'h3

// Timing
`define DFG_CLK_PERIOD_NS 25
`define DFG_US_NS 1000
`define DFG_GF1_US 5
`define DFG_GF2_US 10
`define DFG_GF3_US 20
`define DFG_GF4_US 30
`define DFG_GF5_US 50
`define DFG_GF6_US 75
`define DFG_GF7_US 100
`define DFG_CYC(us) ((us) * `DFG_US_NS / `DFG_CLK_PERIOD_NS)
`define DFG_STR0_US 10
`define DFG_STR1_US 100
`define DFG_STR2_US 1000
`define DFG_STR3_US 10000

`endif

// ===== src/dfg_pkg.sv
package dfg_pkg;

   typedef logic [1:0] dfg_code2_t;

   typedef struct packed {
      logic out;
      logic [11:0] cnt;
   } dfg_filt_state_t;

   typedef struct packed {
      logic [7:0] hi_thr;
      logic [4:0] hi_hys;
      logic [7:0] lo_thr;
      logic [4:0] lo_hys;
      logic [2:0] det_gf;
      dfg_code2_t det_kind;
      dfg_code2_t sel;
      logic flip;
      logic edge_mode;
      dfg_code2_t stretch;
      logic [2:0] gpi_gf;
      logic [2:0] pin_s;
      logic pin_q;
      logic gpi_prev;
      logic [18:0] str_cnt;
      logic fault;
      logic warn;
      logic [7:0] rdata;
   } dfg_state_t;

endpackage

// ===== src/dfg_filter.sv
`timescale 1ns/1ps
`include "dfg_map.svh"

// Output follows the input only after it has held its new level for the coded time
module dfg_filter (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0] gf_code,
   input wire logic din,
   output logic dout
);
   import dfg_pkg::*;

   dfg_filt_state_t st, nx;
   logic [11:0] lim;

   always_comb begin
      case (gf_code)
         3'h1: lim = 12'(`DFG_CYC(`DFG_GF1_US));
         3'h2: lim = 12'(`DFG_CYC(`DFG_GF2_US));
         3'h3: lim = 12'(`DFG_CYC(`DFG_GF3_US));
         3'h4: lim = 12'(`DFG_CYC(`DFG_GF4_US));
         3'h5: lim = 12'(`DFG_CYC(`DFG_GF5_US));
         3'h6: lim = 12'(`DFG_CYC(`DFG_GF6_US));
         3'h7: lim = 12'(`DFG_CYC(`DFG_GF7_US));
         default: lim = 12'h000;
      endcase
   end

   always_comb begin
      nx = st;
      if (din == st.out) begin
         nx.cnt = 12'h000;
      end else if (st.cnt + 12'h001 >= lim) begin
         nx.out = din;
         nx.cnt = 12'h000;
      end else begin
         nx.cnt = st.cnt + 12'h001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign dout = st.out;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   glitch_reject_a: assert property (
      (din != st.out && st.cnt + 12'h001 < lim) |=> (st.out == $past(st.out)))
      else $error("Filter output moved before the reject time");
   glitch_pass_a: assert property (
      (din != st.out && st.cnt + 12'h001 >= lim) |=> (st.out == $past(din) && st.cnt == 12'h000))
      else $error("Filter output missed a held level");
endmodule

// ===== src/dfg_top.sv
`timescale 1ns/1ps
`include "dfg_map.svh"

module dfg_top #(
   parameter int unsigned STR2_CYC = `DFG_CYC(`DFG_STR2_US),
   parameter int unsigned STR3_CYC = `DFG_CYC(`DFG_STR3_US)
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] sample_code,
   input wire logic logic_pin,
   output logic fault_out,
   output logic warn_out,
   output logic high_flag_out,
   output logic low_flag_out
);
   import dfg_pkg::*;

   localparam int unsigned STR0_CYC = `DFG_CYC(`DFG_STR0_US);
   localparam int unsigned STR1_CYC = `DFG_CYC(`DFG_STR1_US);

   logic [1:0] rst_s;
   logic sync_rst_n;
   dfg_state_t st, nx;
   logic high_raw, low_raw, high_flag, low_flag;
   logic gpi_filt, gpi_edge, gpi_val, det_fault;
   logic [18:0] str_len;
   logic [8:0] high_sum, low_lim;

   // Release is synchronous so the register file never leaves reset on a partial edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s <= 2'h0;
      end else begin
         rst_s <= {rst_s[0], 1'b1};
      end
   end
   assign sync_rst_n = rst_s[1];

   // Hysteresis applies only while the flag already stands
   always_comb begin
      high_sum = {1'b0, sample_code} + {4'h0, (high_flag ? st.hi_hys : 5'h00)};
      low_lim = {1'b0, st.lo_thr} + {4'h0, (low_flag ? st.lo_hys : 5'h00)};
      high_raw = high_sum > {1'b0, st.hi_thr};
      low_raw = {1'b0, sample_code} < low_lim;
   end

   dfg_filter u_high_filt (
      .core_clk(core_clk),
      .rst_n(sync_rst_n),
      .gf_code(st.det_gf),
      .din(high_raw),
      .dout(high_flag)
   );

   dfg_filter u_low_filt (
      .core_clk(core_clk),
      .rst_n(sync_rst_n),
      .gf_code(st.det_gf),
      .din(low_raw),
      .dout(low_flag)
   );

   dfg_filter u_gpi_filt (
      .core_clk(core_clk),
      .rst_n(sync_rst_n),
      .gf_code(st.gpi_gf),
      .din(st.pin_q ^ st.flip),
      .dout(gpi_filt)
   );

   always_comb begin
      case (st.det_kind)
         `DFG_KIND_HIGH: det_fault = high_flag;
         `DFG_KIND_BOTH: det_fault = high_flag | low_flag;
         `DFG_KIND_LOW: det_fault = low_flag;
         default: det_fault = 1'b0;
      endcase
      case (st.stretch)
         2'h0: str_len = 19'(STR0_CYC);
         2'h1: str_len = 19'(STR1_CYC);
         2'h2: str_len = 19'(STR2_CYC);
         default: str_len = 19'(STR3_CYC);
      endcase
      gpi_edge = gpi_filt & ~st.gpi_prev;
      gpi_val = st.edge_mode ? (st.str_cnt != 19'h00000) : gpi_filt;
   end

   always_comb begin
      nx = st;
      if (reg_wr) begin
         if (reg_addr == `DFG_HIGH_THRESHOLD_ADDR) begin
            nx.hi_thr = reg_wdata;
         end else if (reg_addr == `DFG_HIGH_BACKOFF_ADDR) begin
            nx.hi_hys = reg_wdata[`DFG_BACKOFF_MSB:0];
         end else if (reg_addr == `DFG_LOW_THRESHOLD_ADDR) begin
            nx.lo_thr = reg_wdata;
         end else if (reg_addr == `DFG_LOW_BACKOFF_ADDR) begin
            nx.lo_hys = reg_wdata[`DFG_BACKOFF_MSB:0];
         end else if (reg_addr == `DFG_DETECTOR_CONFIG_ADDR) begin
            nx.det_gf = reg_wdata[`DFG_DET_GF_MSB:`DFG_DET_GF_LSB];
            nx.det_kind = reg_wdata[`DFG_DET_KIND_MSB:0];
         end else if (reg_addr == `DFG_FUNCTION_CHOICE_ADDR) begin
            nx.sel = reg_wdata[`DFG_SEL_MSB:0];
         end else if (reg_addr == `DFG_LOGIC_INPUT_CONFIG_ADDR) begin
            nx.flip = reg_wdata[`DFG_FLIP_BIT];
            nx.edge_mode = reg_wdata[`DFG_EDGE_BIT];
            nx.stretch = reg_wdata[`DFG_STRETCH_MSB:`DFG_STRETCH_LSB];
            nx.gpi_gf = reg_wdata[`DFG_GPI_GF_MSB:0];
         end
      end
      if (reg_rd) begin
         if (reg_addr == `DFG_HIGH_THRESHOLD_ADDR) begin
            nx.rdata = st.hi_thr;
         end else if (reg_addr == `DFG_HIGH_BACKOFF_ADDR) begin
            nx.rdata = {3'h0, st.hi_hys};
         end else if (reg_addr == `DFG_LOW_THRESHOLD_ADDR) begin
            nx.rdata = st.lo_thr;
         end else if (reg_addr == `DFG_LOW_BACKOFF_ADDR) begin
            nx.rdata = {3'h0, st.lo_hys};
         end else if (reg_addr == `DFG_DETECTOR_CONFIG_ADDR) begin
            nx.rdata = {3'h0, st.det_gf, st.det_kind};
         end else if (reg_addr == `DFG_FUNCTION_CHOICE_ADDR) begin
            nx.rdata = {6'h00, st.sel};
         end else if (reg_addr == `DFG_LOGIC_INPUT_CONFIG_ADDR) begin
            nx.rdata = {1'b0, st.flip, st.edge_mode, st.stretch, st.gpi_gf};
         end else begin
            nx.rdata = 8'h00;
         end
      end
      // Pin crosses in through three stages; only agreeing late stages count
      nx.pin_s = {st.pin_s[1:0], logic_pin};
      if (st.pin_s[1] == st.pin_s[2]) begin
         nx.pin_q = st.pin_s[2];
      end
      nx.gpi_prev = gpi_filt;
      // A fresh edge restarts the pulse rather than queueing a second one
      if (st.edge_mode && gpi_edge) begin
         nx.str_cnt = str_len;
      end else if (st.str_cnt != 19'h00000) begin
         nx.str_cnt = st.str_cnt - 19'h00001;
      end
      case (st.sel)
         `DFG_SEL_DET_FAULT: begin
            nx.fault = det_fault;
            nx.warn = 1'b0;
         end
         `DFG_SEL_GPI_FAULT: begin
            nx.fault = gpi_val;
            nx.warn = 1'b0;
         end
         `DFG_SEL_GPI_FAULT_DET_WARN: begin
            nx.fault = gpi_val;
            nx.warn = det_fault;
         end
         default: begin
            nx.fault = 1'b0;
            nx.warn = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge sync_rst_n) begin
      if (!sync_rst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign reg_rdata = st.rdata;
   assign fault_out = st.fault;
   assign warn_out = st.warn;
   assign high_flag_out = high_flag;
   assign low_flag_out = low_flag;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!sync_rst_n);

   sequence edge_seen;
      st.edge_mode && gpi_filt && !st.gpi_prev;
   endsequence

   sequence short_pulse_cfg;
      st.stretch == 2'h0 && !reg_wr;
   endsequence

   high_backoff_a: assert property (
      (st.det_gf == 3'h0 && high_flag && !reg_wr &&
       ({1'b0, sample_code} + {4'h0, st.hi_hys}) > {1'b0, st.hi_thr}) |=> high_flag)
      else $error("High flag dropped inside its hysteresis band");
   low_backoff_a: assert property (
      (st.det_gf == 3'h0 && low_flag && !reg_wr &&
       {1'b0, sample_code} < ({1'b0, st.lo_thr} + {4'h0, st.lo_hys})) |=> low_flag)
      else $error("Low flag dropped inside its hysteresis band");
   det_route_a: assert property (
      (st.sel == `DFG_SEL_DET_FAULT) |=> (fault_out == $past(det_fault) && !warn_out))
      else $error("Detector fault routing wrong");
   warn_route_a: assert property (
      (st.sel == `DFG_SEL_GPI_FAULT_DET_WARN) |=> (warn_out == $past(det_fault) && fault_out == $past(gpi_val)))
      else $error("Warning routing wrong");
   input_flip_a: assert property (
      (st.gpi_gf == 3'h0 && !reg_wr) |=> (gpi_filt == ($past(st.pin_q) ^ $past(st.flip))))
      else $error("Logic input polarity wrong");
   level_mode_a: assert property (
      (!st.edge_mode && st.sel == `DFG_SEL_GPI_FAULT && !reg_wr) |=> (fault_out == $past(gpi_filt)))
      else $error("Level mode does not follow the input");
   pulse_length_a: assert property (
      (edge_seen and short_pulse_cfg) |=> (st.str_cnt == 19'(STR0_CYC)) ##1 (st.str_cnt != 19'h00000)[*8])
      else $error("Edge pulse not started at its length");
   kind_high_a: assert property (
      (st.sel == `DFG_SEL_DET_FAULT && st.det_kind == `DFG_KIND_HIGH && low_flag && !high_flag && !reg_wr)
      |=> !fault_out)
      else $error("Under flag raised a fault in over-only mode");
   kind_off_a: assert property (
      (st.sel == `DFG_SEL_DET_FAULT && st.det_kind == `DFG_KIND_OFF && !reg_wr) |=> !fault_out)
      else $error("Detector switched off still raised a fault");
endmodule

// ===== bench/dfg_rail_model.sv
`timescale 1ns/1ps

module dfg_rail_model (
   input wire logic core_clk,
   output logic [7:0] sample_code,
   output logic logic_pin
);
   // Rail code and pin are levels, moved only just after a clock edge
   initial begin
      sample_code = 8'h00;
      logic_pin = 1'b0;
   end

   task automatic set_code(input logic [7:0] v);
      @(posedge core_clk);
      sample_code <= v;
   endtask

   task automatic set_pin(input logic v);
      @(posedge core_clk);
      logic_pin <= v;
   endtask
endmodule

// ===== bench/dfg_top_bench.sv
`timescale 1ns/1ps
`include "dfg_map.svh"

module dfg_top_bench;
   logic core_clk = 1'b0;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata, sample_code;
   logic logic_pin, fault_out, warn_out, high_flag_out, low_flag_out;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #12.5 core_clk = ~core_clk;

   dfg_rail_model rail (.core_clk(core_clk), .sample_code(sample_code), .logic_pin(logic_pin));

   // Short stretch lengths keep the long edge-mode codes affordable
   dfg_top #(.STR2_CYC(100), .STR3_CYC(200)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sample_code(sample_code), .logic_pin(logic_pin),
      .fault_out(fault_out), .warn_out(warn_out), .high_flag_out(high_flag_out),
      .low_flag_out(low_flag_out));

   task automatic wrap_up;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      tick(1);
      chk(what, 32'(e), 32'(reg_rdata));
   endtask

   task automatic step(input logic [7:0] c, input logic h, input logic l);
      rail.set_code(c);
      tick(4);
      chk("high flag", 32'(h), 32'(high_flag_out));
      chk("low flag", 32'(l), 32'(low_flag_out));
   endtask

   task automatic t_regs;
      rdchk(`DFG_HIGH_THRESHOLD_ADDR, 8'h00, "reset high_threshold");
      wr(`DFG_HIGH_BACKOFF_ADDR, 8'hFF);
      wr(`DFG_FUNCTION_CHOICE_ADDR, 8'hFF);
      wr(`DFG_LOGIC_INPUT_CONFIG_ADDR, 8'hFF);
      wr(8'h50, 8'hAA);
      rdchk(`DFG_HIGH_BACKOFF_ADDR, 8'h1F, "high_backoff");
      rdchk(`DFG_FUNCTION_CHOICE_ADDR, 8'h03, "function_choice_reg");
      rdchk(`DFG_LOGIC_INPUT_CONFIG_ADDR, 8'h7F, "logic_input_config");
      rdchk(8'h50, 8'h00, "unmapped read");
      $display("test regs done");
   endtask

   task automatic t_hyst;
      wr(`DFG_LOGIC_INPUT_CONFIG_ADDR, 8'h00);
      wr(`DFG_FUNCTION_CHOICE_ADDR, 8'h00);
      wr(`DFG_HIGH_THRESHOLD_ADDR, 8'h80);
      wr(`DFG_HIGH_BACKOFF_ADDR, 8'h05);
      wr(`DFG_LOW_THRESHOLD_ADDR, 8'h40);
      wr(`DFG_LOW_BACKOFF_ADDR, 8'h04);
      step(8'h80, 1'b0, 1'b0);
      step(8'h81, 1'b1, 1'b0);
      step(8'h7C, 1'b1, 1'b0);
      step(8'h7B, 1'b0, 1'b0);
      step(8'h3F, 1'b0, 1'b1);
      step(8'h43, 1'b0, 1'b1);
      step(8'h44, 1'b0, 1'b0);
      $display("test hysteresis done");
   endtask

   task automatic t_kind;
      // Bit k is the expected fault for kind code k
      logic [3:0] hi_exp = 4'b0011;
      logic [3:0] lo_exp = 4'b0110;
      for (int k = 0; k < 4; k++) begin
         wr(`DFG_DETECTOR_CONFIG_ADDR, 8'(k));
         step(8'h90, 1'b1, 1'b0);
         chk("fault over", 32'(hi_exp[k]), 32'(fault_out));
         chk("warn sel 00", 32'h0, 32'(warn_out));
         step(8'h30, 1'b0, 1'b1);
         chk("fault under", 32'(lo_exp[k]), 32'(fault_out));
      end
      $display("test fault kind done");
   endtask

   task automatic t_filter;
      wr(`DFG_DETECTOR_CONFIG_ADDR, 8'h04);
      rail.set_code(8'h90);
      tick(150);
      rail.set_code(8'h30);
      tick(60);
      chk("short pulse ignored", 32'h0, 32'(high_flag_out));
      rail.set_code(8'h90);
      tick(190);
      chk("flag before 200 cycles", 32'h0, 32'(high_flag_out));
      tick(20);
      chk("flag after 200 cycles", 32'h1, 32'(high_flag_out));
      // Longer code must also hold back a falling flag
      wr(`DFG_DETECTOR_CONFIG_ADDR, 8'h08);
      rail.set_code(8'h30);
      tick(390);
      chk("flag held before 400 cycles", 32'h1, 32'(high_flag_out));
      tick(20);
      chk("flag cleared after 400 cycles", 32'h0, 32'(high_flag_out));
      rail.set_code(8'h90);
      $display("test glitch filter done");
   endtask

   task automatic t_level;
      wr(`DFG_DETECTOR_CONFIG_ADDR, 8'h00);
      wr(`DFG_LOGIC_INPUT_CONFIG_ADDR, 8'h01);
      wr(`DFG_FUNCTION_CHOICE_ADDR, 8'h01);
      rail.set_pin(1'b1);
      tick(150);
      chk("level before filter", 32'h0, 32'(fault_out));
      tick(70);
      chk("level fault", 32'h1, 32'(fault_out));
      chk("warn sel 01", 32'h0, 32'(warn_out));
      wr(`DFG_FUNCTION_CHOICE_ADDR, 8'h02);
      tick(3);
      chk("fault sel 10", 32'h1, 32'(fault_out));
      chk("warn sel 10", 32'h1, 32'(warn_out));
      wr(`DFG_LOGIC_INPUT_CONFIG_ADDR, 8'h41);
      tick(220);
      chk("fault inverted", 32'h0, 32'(fault_out));
      wr(`DFG_FUNCTION_CHOICE_ADDR, 8'h03);
      tick(3);
      chk("fault sel 11", 32'h0, 32'(fault_out));
      chk("warn sel 11", 32'h0, 32'(warn_out));
      $display("test level mode done");
   endtask

   task automatic t_edge;
      int lens[4] = '{400, 4000, 100, 200};
      int n;
      wr(`DFG_FUNCTION_CHOICE_ADDR, 8'h01);
      // Flip dropped in level mode first, else it poses as a rising edge
      wr(`DFG_LOGIC_INPUT_CONFIG_ADDR, 8'h00);
      for (int s = 0; s < 4; s++) begin
         rail.set_pin(1'b0);
         wr(`DFG_LOGIC_INPUT_CONFIG_ADDR, 8'(8'h20 | (s << 3)));
         tick(10);
         rail.set_pin(1'b1);
         n = 0;
         while (fault_out !== 1'b1 && n < 20) begin
            tick(1);
            n++;
         end
         // Falling pin inside the pulse must not cut it short
         rail.set_pin(1'b0);
         n = 0;
         while (fault_out === 1'b1 && n < 5000) begin
            tick(1);
            n++;
         end
         chk("pulse length", 32'h1, 32'(n >= lens[s] - 2 && n <= lens[s] + 2));
      end
      $display("test edge mode done");
   endtask

   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      tick(3);
      t_regs();
      t_hyst();
      t_kind();
      t_filter();
      t_level();
      t_edge();
      wrap_up();
   end
endmodule
